// ===== core/mmbd_decoder.sv
// memory map decoder with rom bank select register and axi4-lite access
// Summary of operation
// - addresses 0000H-00BFH go to zero-page working sram.
// - addresses 01C0H-01FFH go to the stack part of sram.
// - addresses 0200H-023FH go to the general part of sram.
// - 0100H-01BFH alias the same sram cells as 0000H-00BFH.
// - 00C0H-00FFH decode to special function registers, not sram.
// - 8000H-FFEDH map to fixed unbanked rom.
// - 4000H-7FFFH shows the 16 KB rom bank named by bank select.
// - bank select is 00H after reset, showing bank zero.
// - bank select at 00D5H holds a read/write bank number in bits 2-0.
// - vector area FFF0H-FFFFH maps to rom for vector fetch.
// - special function registers are whole-byte only, no bit operations.
module mmbd_decoder
   import mmbd_pkg::*;
(
   // clock and reset
   input  wire logic        CLK,
   input  wire logic        RST_B,
   // cpu address port
   input  wire logic [15:0] CPU_ADDR,
   input  wire logic        CPU_RD,
   input  wire logic        CPU_WR,
   input  wire logic [7:0]  CPU_WDATA,
   output logic      [7:0]  CPU_RDATA,
   // memory selects
   input  wire logic [7:0]  SRAM_RDATA,
   input  wire logic [7:0]  SFR_RDATA,
   input  wire logic [7:0]  ROM_RDATA,
   output mmbd_route_s      ROUTE,
   output logic             SRAM_WE,
   output logic             SFR_WE,
   output logic [2:0]       BANK_SEL,
   // axi4-lite slave
   input  wire logic [11:0] S_AXI_AWADDR,
   input  wire logic        S_AXI_AWVALID,
   output logic             S_AXI_AWREADY,
   input  wire logic [31:0] S_AXI_WDATA,
   input  wire logic [3:0]  S_AXI_WSTRB,
   input  wire logic        S_AXI_WVALID,
   output logic             S_AXI_WREADY,
   output logic [1:0]       S_AXI_BRESP,
   output logic             S_AXI_BVALID,
   input  wire logic        S_AXI_BREADY,
   input  wire logic [11:0] S_AXI_ARADDR,
   input  wire logic        S_AXI_ARVALID,
   output logic             S_AXI_ARREADY,
   output logic [31:0]      S_AXI_RDATA,
   output logic [1:0]       S_AXI_RRESP,
   output logic             S_AXI_RVALID,
   input  wire logic        S_AXI_RREADY
);

   function automatic mmbd_region_e region_of(input logic [15:0] a);
      mmbd_region_e r;
      r = REG_NONE;
      if (a <= ZP_HI) r = REG_ZP;
      else if (a >= SFR_LO && a <= SFR_HI) r = REG_SFR;
      else if (a >= SHARE_LO && a <= SHARE_HI) r = REG_ZP;
      else if (a >= STACK_LO && a <= STACK_HI) r = REG_STACK;
      else if (a >= GEN_LO && a <= GEN_HI) r = REG_GEN;
      else if (a >= BANKWIN_LO && a <= BANKWIN_HI) r = REG_BANKROM;
      else if (a >= FIXROM_LO && a <= FIXROM_HI) r = REG_FIXROM;
      else if (a >= VEC_LO) r = REG_VEC;
      return r;
   endfunction : region_of

   logic [2:0]   bank_sel;
   logic [2:0]   next_bank_sel;
   logic [7:0]   cpu_rdata;
   logic [7:0]   next_cpu_rdata;
   mmbd_region_e cpu_reg;
   logic         cpu_bank_hit;

   assign cpu_reg      = region_of(CPU_ADDR);
   assign cpu_bank_hit = (CPU_ADDR == BANK_SEL_ADDR);

   // routing to memories, combinational to keep cpu timing single-cycle
   always_comb begin
      ROUTE = '0;
      case (cpu_reg)
         REG_ZP: begin
            ROUTE.sram_sel  = 1'b1;
            // share alias drops bit 8 so both windows hit one cell
            ROUTE.sram_addr = {1'b0, CPU_ADDR[7:0]};
         end
         REG_STACK, REG_GEN: begin
            ROUTE.sram_sel  = 1'b1;
            ROUTE.sram_addr = CPU_ADDR[8:0] - 9'h100;
         end
         REG_SFR: begin
            ROUTE.sfr_sel  = ~cpu_bank_hit;
            ROUTE.sfr_addr = CPU_ADDR[5:0];
         end
         REG_BANKROM: begin
            ROUTE.rom_sel  = 1'b1;
            // banks 0-5 sit above the 32 KB fixed area; banks 6 and 7 wrap onto it
            ROUTE.rom_addr = {3'(bank_sel + 3'h2), CPU_ADDR[BANK_OFS_W-1:0]};
         end
         REG_FIXROM, REG_VEC: begin
            ROUTE.rom_sel  = 1'b1;
            ROUTE.rom_addr = {2'h0, CPU_ADDR[14:0]};
         end
         default: ROUTE = '0;
      endcase
   end

   // whole-byte strobes only; no bit-level masks exist
   assign SRAM_WE  = CPU_WR & ROUTE.sram_sel;
   assign SFR_WE   = CPU_WR & ROUTE.sfr_sel;
   assign BANK_SEL = bank_sel;

   // axi write channel state
   logic        aw_held;
   logic        next_aw_held;
   logic        w_held;
   logic        next_w_held;
   logic [11:0] aw_addr;
   logic [11:0] next_aw_addr;
   logic [2:0]  w_data;
   logic [2:0]  next_w_data;
   logic        w_lane0;
   logic        next_w_lane0;
   logic        bvalid;
   logic        next_bvalid;
   logic [1:0]  bresp;
   logic [1:0]  next_bresp;
   // axi read channel state
   logic        rvalid;
   logic        next_rvalid;
   logic [31:0] rdata;
   logic [31:0] next_rdata;
   logic [1:0]  rresp;
   logic [1:0]  next_rresp;
   // commit qualifiers and read words
   logic        axi_wr_fire;
   logic        axi_wr_bank;
   logic        axi_wr_status;
   logic [31:0] bank_word;
   logic [31:0] status_word;

   // register index match: word address bits only, byte lanes ignored
   function automatic logic reg_hit(input logic [11:0] addr, input logic [11:0] ofs);
      return addr[11:2] == ofs[11:2];
   endfunction : reg_hit

   // readies drop while a response waits so a second request cannot slip in
   assign S_AXI_AWREADY = ~aw_held & ~bvalid;
   assign S_AXI_WREADY  = ~w_held & ~bvalid;
   assign S_AXI_ARREADY = ~rvalid;
   assign S_AXI_BVALID  = bvalid;
   assign S_AXI_BRESP   = bresp;
   assign S_AXI_RVALID  = rvalid;
   assign S_AXI_RDATA   = rdata;
   assign S_AXI_RRESP   = rresp;
   assign axi_wr_fire   = aw_held & w_held & ~bvalid;
   assign axi_wr_bank   = reg_hit(aw_addr, AXI_BANK_SEL_OFS);
   assign axi_wr_status = reg_hit(aw_addr, AXI_STATUS_OFS);
   assign bank_word     = {29'h0, bank_sel};
   // prohibited bank numbers are stored but flagged for software
   assign status_word   = {28'h0, bank_sel > BANK_MAX, bank_sel};

   // address and data are taken in either order and held until the commit
   always_comb begin
      next_aw_held = aw_held;
      next_w_held  = w_held;
      next_aw_addr = aw_addr;
      next_w_data  = w_data;
      next_w_lane0 = w_lane0;
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
         next_aw_held = 1'b1;
         next_aw_addr = S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
         next_w_held  = 1'b1;
         next_w_data  = S_AXI_WDATA[2:0];
         next_w_lane0 = S_AXI_WSTRB[0];
      end
      if (axi_wr_fire) begin
         next_aw_held = 1'b0;
         next_w_held  = 1'b0;
      end
   end

   // one response per commit; status offset takes writes silently
   always_comb begin
      next_bvalid = bvalid;
      next_bresp  = bresp;
      if (axi_wr_fire) begin
         next_bvalid = 1'b1;
         next_bresp  = (axi_wr_bank || axi_wr_status) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && S_AXI_BREADY) begin
         next_bvalid = 1'b0;
      end
   end

   // bank select: a bus commit wins over a cpu store in the same cycle
   always_comb begin
      next_bank_sel = bank_sel;
      if (axi_wr_fire && axi_wr_bank) begin
         if (w_lane0) next_bank_sel = w_data;
      end else if (CPU_WR && cpu_bank_hit) begin
         next_bank_sel = CPU_WDATA[2:0];
      end
   end

   // read data is latched when the address is taken and held until accepted
   always_comb begin
      next_rvalid = rvalid;
      next_rdata  = rdata;
      next_rresp  = rresp;
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
         next_rvalid = 1'b1;
         next_rresp  = RESP_OKAY;
         if (reg_hit(S_AXI_ARADDR, AXI_BANK_SEL_OFS)) begin
            next_rdata = bank_word;
         end else if (reg_hit(S_AXI_ARADDR, AXI_STATUS_OFS)) begin
            next_rdata = status_word;
         end else begin
            next_rdata = 32'h0;
            next_rresp = RESP_SLVERR;
         end
      end else if (rvalid && S_AXI_RREADY) begin
         next_rvalid = 1'b0;
      end
   end

   // cpu read data mux, registered one cycle after the address
   always_comb begin
      next_cpu_rdata = 8'h00;
      if (CPU_RD) begin
         if (cpu_bank_hit) begin
            next_cpu_rdata = bank_word[7:0];
         end else begin
            case (cpu_reg)
               REG_ZP, REG_STACK, REG_GEN:       next_cpu_rdata = SRAM_RDATA;
               REG_SFR:                          next_cpu_rdata = SFR_RDATA;
               REG_BANKROM, REG_FIXROM, REG_VEC: next_cpu_rdata = ROM_RDATA;
               default:                          next_cpu_rdata = 8'h00;
            endcase
         end
      end
   end
   assign CPU_RDATA = cpu_rdata;

   // bank select register
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         bank_sel <= BANK_SEL_RESET[2:0];
      end else begin
         bank_sel <= next_bank_sel;
      end
   end

   // cpu read data register
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         cpu_rdata <= 8'h00;
      end else begin
         cpu_rdata <= next_cpu_rdata;
      end
   end

   // write address and data holding registers
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         aw_addr <= 12'h000;
         w_data  <= 3'h0;
         w_lane0 <= 1'b0;
      end else begin
         aw_held <= next_aw_held;
         w_held  <= next_w_held;
         aw_addr <= next_aw_addr;
         w_data  <= next_w_data;
         w_lane0 <= next_w_lane0;
      end
   end

   // write response registers
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         bvalid <= 1'b0;
         bresp  <= 2'h0;
      end else begin
         bvalid <= next_bvalid;
         bresp  <= next_bresp;
      end
   end

   // read response registers
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         rvalid <= 1'b0;
         rdata  <= 32'h0;
         rresp  <= 2'h0;
      end else begin
         rvalid <= next_rvalid;
         rdata  <= next_rdata;
         rresp  <= next_rresp;
      end
   end
endmodule : mmbd_decoder

// ===== core/mmbd_pkg.sv
// package: address map, bank register layout and bus types for the memory map decoder
package mmbd_pkg;
   localparam logic [15:0] ZP_LO       = 16'h0000;
   localparam logic [15:0] ZP_HI       = 16'h00BF;
   localparam logic [15:0] SFR_LO      = 16'h00C0;
   localparam logic [15:0] SFR_HI      = 16'h00FF;
   localparam logic [15:0] SHARE_LO    = 16'h0100;
   localparam logic [15:0] SHARE_HI    = 16'h01BF;
   localparam logic [15:0] STACK_LO    = 16'h01C0;
   localparam logic [15:0] STACK_HI    = 16'h01FF;
   localparam logic [15:0] GEN_LO      = 16'h0200;
   localparam logic [15:0] GEN_HI      = 16'h023F;
   localparam logic [15:0] BANKWIN_LO  = 16'h4000;
   localparam logic [15:0] BANKWIN_HI  = 16'h7FFF;
   localparam logic [15:0] FIXROM_LO   = 16'h8000;
   localparam logic [15:0] FIXROM_HI   = 16'hFFED;
   localparam logic [15:0] VEC_LO      = 16'hFFF0;
   localparam logic [15:0] VEC_HI      = 16'hFFFF;
   localparam logic [15:0] BANK_SEL_ADDR = 16'h00D5;
   localparam logic [7:0]  BANK_SEL_RESET = 8'h00;
   localparam logic [2:0]  BANK_MAX    = 3'h5;
   localparam int          BANK_W      = 3;
   localparam int          BANK_OFS_W  = 14;
   localparam int          SRAM_AW     = 9;
   localparam int          ROM_AW      = 17;
   // byte offsets of the AXI4-Lite registers
   localparam logic [11:0] AXI_BANK_SEL_OFS = 12'h0D5 << 2;
   localparam logic [11:0] AXI_STATUS_OFS   = 12'h004;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   typedef enum { REG_NONE, REG_ZP, REG_SFR, REG_STACK, REG_GEN, REG_BANKROM,
                  REG_FIXROM, REG_VEC } mmbd_region_e;

   typedef struct packed {
      logic       sram_sel;
      logic [8:0] sram_addr;
      logic       sfr_sel;
      logic [5:0] sfr_addr;
      logic       rom_sel;
      logic [16:0] rom_addr;
   } mmbd_route_s;
endpackage : mmbd_pkg

// ===== dv/mmbd_decoder_monitor.sv
// checker: address routing and bank select relations of the decoder
module mmbd_decoder_monitor
   import mmbd_pkg::*;
(
   // clock and reset
   input wire logic        CLK,
   input wire logic        RST_B,
   // cpu side
   input wire logic [15:0] CPU_ADDR,
   input wire logic        CPU_WR,
   input wire logic [7:0]  CPU_WDATA,
   input wire logic [7:0]  CPU_RDATA,
   input wire mmbd_route_s ROUTE,
   input wire logic        SRAM_WE,
   input wire logic        SFR_WE,
   input wire logic [2:0]  BANK_SEL
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_B);
   logic [15:0] a;
   assign a = CPU_ADDR;
   property p_zp; a <= ZP_HI || a inside {[SHARE_LO:SHARE_HI]}
      |-> ROUTE.sram_sel && ROUTE.sram_addr == {1'h0, a[7:0]}; endproperty
   a_zp: assert property (p_zp) else $error("zero page route");
   property p_stk; a inside {[STACK_LO:STACK_HI]}
      |-> ROUTE.sram_sel && ROUTE.sram_addr == {3'h3, a[5:0]}; endproperty
   a_stk: assert property (p_stk) else $error("stack route");
   property p_gen; a inside {[GEN_LO:GEN_HI]}
      |-> ROUTE.sram_sel && ROUTE.sram_addr == {3'h4, a[5:0]}; endproperty
   a_gen: assert property (p_gen) else $error("general ram route");
   property p_sfr; a inside {[SFR_LO:SFR_HI]} && a != BANK_SEL_ADDR |-> ROUTE.sfr_sel
      && !ROUTE.sram_sel && ROUTE.sfr_addr == a[5:0] && SFR_WE == CPU_WR; endproperty
   a_sfr: assert property (p_sfr) else $error("sfr route");
   property p_fix; a >= FIXROM_LO && !(a inside {16'hFFEE, 16'hFFEF})
      |-> ROUTE.rom_sel && ROUTE.rom_addr == {2'h0, a[14:0]}; endproperty
   a_fix: assert property (p_fix) else $error("fixed rom route");
   property p_win; a inside {[BANKWIN_LO:BANKWIN_HI]}
      |-> ROUTE.rom_sel && ROUTE.rom_addr == {BANK_SEL + 3'h2, a[13:0]}; endproperty
   a_win: assert property (p_win) else $error("bank window route");
   property p_bank; CPU_WR && a == BANK_SEL_ADDR
      |=> BANK_SEL == 3'($past(CPU_WDATA)); endproperty
   a_bank: assert property (p_bank) else $error("bank load");
   property p_none; a inside {[16'h0240:16'h3FFF], 16'hFFEE, 16'hFFEF} |-> !ROUTE.sram_sel
      && !ROUTE.sfr_sel && !ROUTE.rom_sel && !SRAM_WE ##1 CPU_RDATA == 8'h00; endproperty
   a_none: assert property (p_none) else $error("undecoded access");
endmodule : mmbd_decoder_monitor

bind mmbd_decoder mmbd_decoder_monitor u_mon (.CLK, .RST_B, .CPU_ADDR, .CPU_WR, .CPU_WDATA,
   .CPU_RDATA, .ROUTE, .SRAM_WE, .SFR_WE, .BANK_SEL);

// ===== dv/mmbd_mem_model.sv
// memory model: data is a plain function of the routed address
module mmbd_mem_model
   import mmbd_pkg::*;
(
   input wire logic        CLK,
   input wire mmbd_route_s ROUTE,
   output logic [7:0]      SRAM_RDATA,
   output logic [7:0]      SFR_RDATA,
   output logic [7:0]      ROM_RDATA
);
   timeunit 1ns;
   timeprecision 1ps;
   // unselected parts show changing junk, never the last value
   logic [7:0] junk = 8'h5A;
   always @(posedge CLK) junk <= ~junk + 8'h01;
   assign SRAM_RDATA = ROUTE.sram_sel ? ROUTE.sram_addr[8:1] : junk;
   assign SFR_RDATA  = ROUTE.sfr_sel ? {2'h2, ROUTE.sfr_addr} : junk;
   assign ROM_RDATA  = ROUTE.rom_sel ? ROUTE.rom_addr[16:9] ^ ROUTE.rom_addr[7:0] : junk;
endmodule : mmbd_mem_model

// ===== dv/mmbd_decoder_bench.sv
// testbench: cpu and axi4-lite accesses with expected data
module mmbd_decoder_bench
   import mmbd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        CLK = 1'b0, RST_B = 1'b0, CPU_RD = 1'b0, CPU_WR = 1'b0;
   logic [15:0] CPU_ADDR = 16'h0000;
   logic [7:0]  CPU_WDATA = 8'h00, CPU_RDATA, SRAM_RDATA, SFR_RDATA, ROM_RDATA;
   logic        S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_ARVALID = 1'b0;
   logic        S_AXI_BREADY = 1'b0, S_AXI_RREADY = 1'b0, SRAM_WE, SFR_WE;
   logic        S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
   logic [11:0] S_AXI_AWADDR = 12'h000, S_AXI_ARADDR = 12'h000;
   logic [31:0] S_AXI_WDATA = 32'h00000000, S_AXI_RDATA, rd;
   logic [3:0]  S_AXI_WSTRB = 4'hF;
   logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, rsp;
   logic [2:0]  BANK_SEL;
   mmbd_route_s ROUTE;
   int          miscompares = 0, num_checks = 0;
   // address and expected byte, memory data as the model gives it
   logic [23:0] tbl [12] = '{24'h001008, 24'h011008, 24'h01C562, 24'h020582, 24'h023F9F,
      24'h00C383, 24'h812323, 24'hFFEDD2, 24'hFFF2CD, 24'h024000, 24'hFFEE00, 24'h3FFF00};

   mmbd_decoder dut (.CLK, .RST_B, .CPU_ADDR, .CPU_RD, .CPU_WR, .CPU_WDATA, .CPU_RDATA,
      .SRAM_RDATA, .SFR_RDATA, .ROM_RDATA, .ROUTE, .SRAM_WE, .SFR_WE, .BANK_SEL,
      .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB,
      .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY,
      .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP,
      .S_AXI_RVALID, .S_AXI_RREADY);
   mmbd_mem_model u_mem (.CLK, .ROUTE, .SRAM_RDATA, .SFR_RDATA, .ROM_RDATA);

   initial forever #12.5 CLK = ~CLK;

   task give_verdict;
      if (miscompares == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : give_verdict

   task chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task tmo(input int n);
      if (n >= 40) begin
         chk(32'h0, 32'h1);
         give_verdict;
      end
   endtask : tmo

   task cpu_rd(input logic [15:0] a, input logic [7:0] e);
      @(posedge CLK);
      CPU_ADDR <= a;
      CPU_RD <= 1'b1;
      @(posedge CLK);
      CPU_RD <= 1'b0;
      #1 chk(32'(CPU_RDATA), 32'(e));
   endtask : cpu_rd

   task cpu_wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge CLK);
      CPU_ADDR <= a;
      CPU_WDATA <= d;
      CPU_WR <= 1'b1;
      @(posedge CLK);
      CPU_WR <= 1'b0;
   endtask : cpu_wr

   task axi_wr(input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge CLK);
      S_AXI_AWADDR <= a;
      S_AXI_WDATA <= d;
      S_AXI_AWVALID <= 1'b1;
      S_AXI_WVALID <= 1'b1;
      S_AXI_BREADY <= 1'b1;
      do begin
         @(posedge CLK);
         n++;
         if (S_AXI_AWREADY === 1'b1) S_AXI_AWVALID <= 1'b0;
         if (S_AXI_WREADY === 1'b1) S_AXI_WVALID <= 1'b0;
      end while (S_AXI_BVALID !== 1'b1 && n < 40);
      rsp = S_AXI_BRESP;
      S_AXI_BREADY <= 1'b0;
      tmo(n);
   endtask : axi_wr

   task axi_rd(input logic [11:0] a);
      int n;
      n = 0;
      @(posedge CLK);
      S_AXI_ARADDR <= a;
      S_AXI_ARVALID <= 1'b1;
      S_AXI_RREADY <= 1'b1;
      do begin
         @(posedge CLK);
         n++;
         if (S_AXI_ARREADY === 1'b1) S_AXI_ARVALID <= 1'b0;
      end while (S_AXI_RVALID !== 1'b1 && n < 40);
      rd = S_AXI_RDATA;
      rsp = S_AXI_RRESP;
      S_AXI_RREADY <= 1'b0;
      tmo(n);
   endtask : axi_rd

   initial begin
      repeat (6) @(posedge CLK);
      RST_B <= 1'b1;
      cpu_rd(BANK_SEL_ADDR, 8'h00);
      cpu_rd(BANKWIN_LO, 8'h40);
      foreach (tbl[i]) cpu_rd(tbl[i][23:8], tbl[i][7:0]);
      cpu_wr(16'h0300, 8'h55);
      // banks stay within the permitted range
      for (int b = 0; b <= 5; b++) begin
         cpu_wr(BANK_SEL_ADDR, 8'hF8 | 8'(b));
         cpu_rd(BANK_SEL_ADDR, 8'(b));
         cpu_rd(BANKWIN_LO + 16'h0001, (8'(b) + 8'h02) << 5 ^ 8'h01);
      end
      axi_wr(AXI_BANK_SEL_OFS, 32'hFFFFFFFA);
      chk(32'(rsp), 32'(RESP_OKAY));
      axi_rd(AXI_BANK_SEL_OFS);
      chk(rd, 32'h00000002);
      cpu_rd(BANK_SEL_ADDR, 8'h02);
      axi_wr(12'h100, 32'h00000001);
      chk(32'(rsp), 32'(RESP_SLVERR));
      axi_rd(12'h100);
      chk(rd, 32'h00000000);
      axi_rd(AXI_BANK_SEL_OFS);
      chk(rd, 32'h00000002);
      axi_rd(AXI_STATUS_OFS);
      chk(rd, 32'h00000002);
      S_AXI_WSTRB <= 4'hE;
      axi_wr(AXI_BANK_SEL_OFS, 32'h00000005);
      S_AXI_WSTRB <= 4'hF;
      chk(32'(BANK_SEL), 32'h00000002);
      RST_B <= 1'b0;
      repeat (2) @(posedge CLK);
      RST_B <= 1'b1;
      cpu_rd(BANKWIN_LO, 8'h40);
      give_verdict;
   end
endmodule : mmbd_decoder_bench
